// ===== mdseq_cfg.svh
/*
 Register indices, field positions, reset values and timing counts
 of the mission datalog sequencer.
 Assumes inclusion by the sequencer module and by the testbench only.
*/
`ifndef MDSEQ_CFG_SVH
`define MDSEQ_CFG_SVH

// ----------------------------------------
// Register indices (byte address = 4 x index)
// ----------------------------------------
`define MDSEQ_IDX_SETTLE 14'h0400
`define MDSEQ_IDX_TCR_LO 14'h0404
`define MDSEQ_IDX_TCR_HI 14'h0405
`define MDSEQ_IDX_TCL_LO 14'h0406
`define MDSEQ_IDX_TCL_HI 14'h0407
`define MDSEQ_IDX_CTRL 14'h0408
`define MDSEQ_IDX_INTERVAL 14'h0409
`define MDSEQ_IDX_START_DLY 14'h040a
`define MDSEQ_IDX_CMD 14'h040b
`define MDSEQ_IDX_STATUS 14'h040c
`define MDSEQ_IDX_MCOUNT 14'h040d
`define MDSEQ_IDX_DCOUNT 14'h040e
`define MDSEQ_IDX_STAMP 14'h040f
`define MDSEQ_IDX_PASSWORD 14'h0410
`define MDSEQ_IDX_GP 14'h0411

// ----------------------------------------
// Reset values
// ----------------------------------------
`define MDSEQ_RST_SETTLE 8'h08
`define MDSEQ_RST_TCR_LO 8'h6b
`define MDSEQ_RST_TCR_HI 5'h11
`define MDSEQ_RST_TCL_LO 8'ha6
`define MDSEQ_RST_TCL_HI 5'h12
`define MDSEQ_RST_INTERVAL 14'h0001

// ----------------------------------------
// Control and command bits
// ----------------------------------------
`define MDSEQ_CTL_WRAP 0
`define MDSEQ_CTL_HSS 1
`define MDSEQ_CTL_START_ON_TEMP_ALARM 2
`define MDSEQ_CTL_ETL 3
`define MDSEQ_CTL_EDL 4
`define MDSEQ_CTL_T16 5
`define MDSEQ_CTL_D16 6
`define MDSEQ_CTL_ALEN 7
`define MDSEQ_CMD_START 0
`define MDSEQ_CMD_STOP 1
`define MDSEQ_CMD_CLEAR 2

// ----------------------------------------
// Section sizes in bytes
// ----------------------------------------
`define MDSEQ_SZ_FULL 14'h2000
`define MDSEQ_SZ_HALF 14'h1000
`define MDSEQ_SZ_MIX8 14'h0a00
`define MDSEQ_SZ_MIX16 14'h1400

// ----------------------------------------
// Timing
// ----------------------------------------
`define MDSEQ_PCLK_NS 5
`define MDSEQ_SETTLE_TICK_NS 500000
`define MDSEQ_SEC_PER_MIN 6'd59

`endif

// ===== mdseq_pkg.sv
/*
 Types of the mission datalog sequencer: state encoding and the
 packed state record.
 Assumes mdseq_cfg.svh is on the include path.
*/
package mdseq_pkg;

  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic [2:0] {
    MDSEQ_IDLE = 3'b000,
    MDSEQ_DELAY = 3'b001,
    MDSEQ_WAIT_ALARM = 3'b011,
    MDSEQ_RUN = 3'b010,
    MDSEQ_SETTLE = 3'b110,
    MDSEQ_WR_TEMP = 3'b111,
    MDSEQ_WR_DATA = 3'b101
  } mdseq_state_t;

  // ----------------------------------------
  // Whole module state
  // ----------------------------------------
  typedef struct packed {
    mdseq_state_t st;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] settle;
    logic [7:0] tcr_lo;
    logic [4:0] tcr_hi;
    logic [7:0] tcl_lo;
    logic [4:0] tcl_hi;
    logic [10:0] ctrl;
    logic [13:0] interval;
    logic [15:0] start_dly;
    logic [31:0] gp;
    logic active;
    logic mem_clr;
    logic [3:0] flags;
    logic [23:0] mcount;
    logic [23:0] dcount;
    logic [31:0] stamp;
    logic [5:0] sec_cnt;
    logic [15:0] dly_cnt;
    logic [13:0] int_cnt;
    logic [16:0] tick_cnt;
    logic [7:0] set_cnt;
    logic [15:0] ext_s1;
    logic [15:0] ext_s2;
    logic [15:0] ext_lat;
    logic hb;
    logic [12:0] tptr;
    logic [12:0] dptr;
    logic tfull;
    logic dfull;
    logic pump_n;
    logic strobe;
    logic log_we;
    logic [12:0] log_addr;
    logic [7:0] log_wdata;
    logic search;
  } mdseq_state_rec_t;

endpackage

// ===== mdseq_seq.sv
/*
 Mission datalog sequencer: APB register slave, mission timing,
 converter settle/strobe timing and datalog byte writer.
 Assumes second ticks and alarm conditions come from logic on pclk,
 and that ext_data arrives from pins outside the clock domain.
*/
`timescale 1ns/1ps
`include "mdseq_cfg.svh"

module mdseq_seq #(
  parameter int TICK_CYCLES = `MDSEQ_SETTLE_TICK_NS / `MDSEQ_PCLK_NS
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Clock and sensing sources
  input wire logic sec_tick,
  input wire logic [31:0] rtc_time,
  input wire logic [15:0] temp_sample,
  input wire logic [3:0] alarm_cond,
  // Converter pins
  input wire logic [15:0] ext_data,
  output logic pump_enable_n,
  output logic conversion_strobe,
  // Datalog memory port
  output logic log_we,
  output logic [12:0] log_addr,
  output logic [7:0] log_wdata,
  // Status
  output logic search_respond,
  output logic mission_active_flag
);

  mdseq_pkg::mdseq_state_rec_t q;
  mdseq_pkg::mdseq_state_rec_t d;

  logic [13:0] idx;
  logic setup;
  logic wr;
  logic cmd_start;
  logic cmd_stop;
  logic cmd_clear;
  logic min_tick;
  logic unit_tick;
  logic both;
  logic t16;
  logic d16;
  logic wrap;
  logic [13:0] tsz;
  logic [13:0] dsz;
  logic [12:0] dbase;
  logic [13:0] nxt;
  logic [31:0] rd;
  logic hit;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  assign idx = paddr[15:2];
  assign setup = psel & ~penable;
  assign wr = psel & penable & q.pready & pwrite;
  assign cmd_start = wr && idx == `MDSEQ_IDX_CMD && pwdata[`MDSEQ_CMD_START];
  assign cmd_stop = wr && idx == `MDSEQ_IDX_CMD && pwdata[`MDSEQ_CMD_STOP];
  assign cmd_clear = wr && idx == `MDSEQ_IDX_CMD && pwdata[`MDSEQ_CMD_CLEAR];
  assign min_tick = sec_tick && q.sec_cnt == `MDSEQ_SEC_PER_MIN;
  assign unit_tick = q.ctrl[`MDSEQ_CTL_HSS] ? sec_tick : min_tick;
  assign both = q.ctrl[`MDSEQ_CTL_ETL] & q.ctrl[`MDSEQ_CTL_EDL];
  assign t16 = q.ctrl[`MDSEQ_CTL_T16];
  assign d16 = q.ctrl[`MDSEQ_CTL_D16];
  assign wrap = q.ctrl[`MDSEQ_CTL_WRAP];

  // ----------------------------------------
  // Section layout
  // ----------------------------------------
  // Section sizes
  always_comb begin
    if (!both) begin
      tsz = `MDSEQ_SZ_FULL;
      dsz = `MDSEQ_SZ_FULL;
    end else if (t16 == d16) begin
      tsz = `MDSEQ_SZ_HALF;
      dsz = `MDSEQ_SZ_HALF;
    end else begin
      tsz = t16 ? `MDSEQ_SZ_MIX16 : `MDSEQ_SZ_MIX8;
      dsz = d16 ? `MDSEQ_SZ_MIX16 : `MDSEQ_SZ_MIX8;
    end
    dbase = both ? tsz[12:0] : 13'h0000;
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always_comb begin
    rd = 32'h0000_0000;
    hit = 1'b1;
    unique case (idx)
      `MDSEQ_IDX_SETTLE: rd[7:0] = q.settle;
      `MDSEQ_IDX_TCR_LO: rd[7:0] = q.tcr_lo;
      `MDSEQ_IDX_TCR_HI: rd[4:0] = q.tcr_hi;
      `MDSEQ_IDX_TCL_LO: rd[7:0] = q.tcl_lo;
      `MDSEQ_IDX_TCL_HI: rd[4:0] = q.tcl_hi;
      `MDSEQ_IDX_CTRL: rd[10:0] = q.ctrl;
      `MDSEQ_IDX_INTERVAL: rd[13:0] = q.interval;
      `MDSEQ_IDX_START_DLY: rd[15:0] = q.start_dly;
      `MDSEQ_IDX_CMD: rd = 32'h0000_0000;
      `MDSEQ_IDX_STATUS: rd[8:0] = {q.flags, q.dfull, q.tfull,
                                    q.st == mdseq_pkg::MDSEQ_WAIT_ALARM, q.mem_clr, q.active};
      `MDSEQ_IDX_MCOUNT: rd[23:0] = q.mcount;
      `MDSEQ_IDX_DCOUNT: rd[23:0] = q.dcount;
      `MDSEQ_IDX_STAMP: rd = q.stamp;
      `MDSEQ_IDX_PASSWORD: rd = 32'h0000_0000;
      `MDSEQ_IDX_GP: rd = q.gp;
      default: hit = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    d = q;
    nxt = 14'h0000;
    d.strobe = 1'b0;
    d.log_we = 1'b0;
    // Bus answer is prepared during setup so it comes from flops
    d.pready = setup;
    d.pslverr = setup & ~hit;
    if (setup) begin
      d.prdata = rd;
    end
    if (wr) begin
      unique case (idx)
        `MDSEQ_IDX_SETTLE: begin
          if (!q.active) begin
            d.settle = pwdata[7:0];
          end
        end
        `MDSEQ_IDX_TCR_LO: d.tcr_lo = pwdata[7:0];
        `MDSEQ_IDX_TCR_HI: d.tcr_hi = pwdata[4:0];
        `MDSEQ_IDX_TCL_LO: d.tcl_lo = pwdata[7:0];
        `MDSEQ_IDX_TCL_HI: d.tcl_hi = pwdata[4:0];
        `MDSEQ_IDX_CTRL: begin
          if (!q.active) begin
            d.ctrl = pwdata[10:0];
          end
        end
        `MDSEQ_IDX_INTERVAL: begin
          if (!q.active) begin
            d.interval = pwdata[13:0];
          end
        end
        `MDSEQ_IDX_START_DLY: begin
          if (!q.active) begin
            d.start_dly = pwdata[15:0];
          end
        end
        `MDSEQ_IDX_GP: d.gp = pwdata;
        default: d.gp = q.gp;
      endcase
    end

    // External data: two flops before use
    d.ext_s1 = ext_data;
    d.ext_s2 = q.ext_s1;

    if (sec_tick) begin
      d.sec_cnt = min_tick ? 6'd0 : q.sec_cnt + 6'd1;
    end

    // Sticky alarms, set wins over clear
    d.flags = (cmd_clear && !q.active) ? 4'h0 : q.flags;
    if (q.active) begin
      d.flags = d.flags | alarm_cond;
    end
    d.search = |(q.flags & q.ctrl[10:7]);

    if (cmd_clear && !q.active) begin
      d.mem_clr = 1'b1;
      d.mcount = 24'h00_0000;
      d.dcount = 24'h00_0000;
      d.stamp = 32'h0000_0000;
      d.tptr = 13'h0000;
      d.dptr = 13'h0000;
      d.tfull = 1'b0;
      d.dfull = 1'b0;
    end

    unique case (q.st)
      mdseq_pkg::MDSEQ_IDLE: begin
        if (cmd_start) begin
          d.active = 1'b1;
          d.mem_clr = 1'b0;
          d.dly_cnt = q.start_dly;
          d.st = mdseq_pkg::MDSEQ_DELAY;
        end
      end
      mdseq_pkg::MDSEQ_DELAY: begin
        d.int_cnt = q.interval;
        if (q.dly_cnt == 16'h0000) begin
          if (q.ctrl[`MDSEQ_CTL_START_ON_TEMP_ALARM] && q.ctrl[`MDSEQ_CTL_ETL]) begin
            d.st = mdseq_pkg::MDSEQ_WAIT_ALARM;
          end else begin
            d.stamp = rtc_time;
            d.hb = 1'b0;
            d.pump_n = ~q.ctrl[`MDSEQ_CTL_EDL];
            d.tick_cnt = 17'h0_0000;
            d.set_cnt = 8'h00;
            d.st = q.ctrl[`MDSEQ_CTL_EDL] ? mdseq_pkg::MDSEQ_SETTLE : mdseq_pkg::MDSEQ_WR_TEMP;
          end
        end else if (min_tick) begin
          d.dly_cnt = q.dly_cnt - 16'h0001;
        end
      end
      mdseq_pkg::MDSEQ_WAIT_ALARM: begin
        if (unit_tick) begin
          if (q.int_cnt <= 14'h0001) begin
            d.int_cnt = q.interval;
            d.dcount = q.dcount + 24'h00_0001;
            // Stamp now, log a period later
            if (alarm_cond[1:0] != 2'b00) begin
              d.stamp = rtc_time;
              d.st = mdseq_pkg::MDSEQ_RUN;
            end
          end else begin
            d.int_cnt = q.int_cnt - 14'h0001;
          end
        end
      end
      mdseq_pkg::MDSEQ_RUN: begin
        if (unit_tick) begin
          if (q.int_cnt <= 14'h0001) begin
            d.int_cnt = q.interval;
            d.hb = 1'b0;
            d.pump_n = ~q.ctrl[`MDSEQ_CTL_EDL];
            d.tick_cnt = 17'h0_0000;
            d.set_cnt = 8'h00;
            d.st = q.ctrl[`MDSEQ_CTL_EDL] ? mdseq_pkg::MDSEQ_SETTLE : mdseq_pkg::MDSEQ_WR_TEMP;
          end else begin
            d.int_cnt = q.int_cnt - 14'h0001;
          end
        end
      end
      mdseq_pkg::MDSEQ_SETTLE: begin
        // Count half-ms ticks to the preset
        if (q.set_cnt == q.settle) begin
          d.strobe = 1'b1;
          d.pump_n = 1'b1;
          d.ext_lat = q.ext_s2;
          d.st = mdseq_pkg::MDSEQ_WR_TEMP;
        end else if (q.tick_cnt == 17'(TICK_CYCLES - 1)) begin
          d.tick_cnt = 17'h0_0000;
          d.set_cnt = q.set_cnt + 8'h01;
        end else begin
          d.tick_cnt = q.tick_cnt + 17'h0_0001;
        end
      end
      mdseq_pkg::MDSEQ_WR_TEMP: begin
        if (q.ctrl[`MDSEQ_CTL_ETL] && !q.tfull) begin
          d.log_we = 1'b1;
          d.log_addr = q.tptr;
          d.log_wdata = (t16 && q.hb) ? temp_sample[7:0] : temp_sample[15:8];
          nxt = {1'b0, q.tptr} + 14'h0001;
          if (t16 && !q.hb) begin
            d.hb = 1'b1;
            d.tptr = nxt[12:0];
          end else begin
            d.hb = 1'b0;
            d.st = mdseq_pkg::MDSEQ_WR_DATA;
            if (nxt == tsz) begin
              d.tptr = 13'h0000;
              d.tfull = ~wrap;
            end else begin
              d.tptr = nxt[12:0];
            end
          end
        end else begin
          d.hb = 1'b0;
          d.st = mdseq_pkg::MDSEQ_WR_DATA;
        end
      end
      mdseq_pkg::MDSEQ_WR_DATA: begin
        if (q.ctrl[`MDSEQ_CTL_EDL] && !q.dfull && (!d16 || !q.hb)) begin
          d.log_we = 1'b1;
          d.log_addr = dbase + q.dptr;
          d.log_wdata = q.ext_lat[15:8];
          nxt = {1'b0, q.dptr} + 14'h0001;
          if (d16) begin
            d.hb = 1'b1;
            d.dptr = nxt[12:0];
          end else begin
            d.st = mdseq_pkg::MDSEQ_RUN;
            if (nxt == dsz) begin
              d.dptr = 13'h0000;
              d.dfull = ~wrap;
            end else begin
              d.dptr = nxt[12:0];
            end
          end
        end else if (q.ctrl[`MDSEQ_CTL_EDL] && !q.dfull) begin
          d.log_we = 1'b1;
          d.log_addr = dbase + q.dptr;
          d.log_wdata = q.ext_lat[7:0];
          d.hb = 1'b0;
          d.st = mdseq_pkg::MDSEQ_RUN;
          nxt = {1'b0, q.dptr} + 14'h0001;
          if (nxt == dsz) begin
            d.dptr = 13'h0000;
            d.dfull = ~wrap;
          end else begin
            d.dptr = nxt[12:0];
          end
        end else begin
          d.st = mdseq_pkg::MDSEQ_RUN;
        end
        if (d.st == mdseq_pkg::MDSEQ_RUN) begin
          d.mcount = q.mcount + 24'h00_0001;
          d.dcount = q.dcount + 24'h00_0001;
        end
      end
      default: d.st = mdseq_pkg::MDSEQ_IDLE;
    endcase

    // Stop overrides any mission step
    if (cmd_stop) begin
      d.active = 1'b0;
      d.pump_n = 1'b1;
      d.st = mdseq_pkg::MDSEQ_IDLE;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.settle <= `MDSEQ_RST_SETTLE;
      q.tcr_lo <= `MDSEQ_RST_TCR_LO;
      q.tcr_hi <= `MDSEQ_RST_TCR_HI;
      q.tcl_lo <= `MDSEQ_RST_TCL_LO;
      q.tcl_hi <= `MDSEQ_RST_TCL_HI;
      q.interval <= `MDSEQ_RST_INTERVAL;
      q.pump_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign pump_enable_n = q.pump_n;
  assign conversion_strobe = q.strobe;
  assign log_we = q.log_we;
  assign log_addr = q.log_addr;
  assign log_wdata = q.log_wdata;
  assign search_respond = q.search;
  assign mission_active_flag = q.active;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_rd_setup(logic [13:0] a);
    setup && !pwrite && idx == a;
  endsequence

  a_settle_locked: assert property (
    wr && idx == `MDSEQ_IDX_SETTLE && q.active |=> $stable(q.settle))
    else $error("settle preset changed during mission");
  a_trim_high_zero: assert property (
    s_rd_setup(`MDSEQ_IDX_TCR_HI) or s_rd_setup(`MDSEQ_IDX_TCL_HI) |=> prdata[31:5] == 27'h0)
    else $error("trim high byte upper bits not zero");
  a_password_zero: assert property (
    s_rd_setup(`MDSEQ_IDX_PASSWORD) |=> pready && prdata == 32'h0000_0000)
    else $error("password read not zero");
  a_start_flags: assert property (
    cmd_start && q.st == mdseq_pkg::MDSEQ_IDLE && !cmd_stop |=> mission_active_flag && !q.mem_clr)
    else $error("start did not set flags");
  a_strobe_pump: assert property (
    conversion_strobe |-> $past(pump_enable_n) == 1'b0 && $past(q.set_cnt) == q.settle)
    else $error("strobe outside settle window");
  a_zero_preset: assert property (
    $fell(pump_enable_n) && q.settle == 8'h00 && !cmd_stop |=> conversion_strobe)
    else $error("zero preset strobe late");
  a_counters_pair: assert property (
    q.mcount == $past(q.mcount) + 24'h00_0001 |-> q.dcount == $past(q.dcount) + 24'h00_0001)
    else $error("mission count moved alone");
  a_ptr_bound: assert property (
    {1'b0, q.tptr} < tsz && {1'b0, q.dptr} < dsz)
    else $error("pointer beyond section");
  a_search_flag: assert property (
    ##1 search_respond == |($past(q.flags) & $past(q.ctrl[10:7])))
    else $error("search answer wrong");
  a_bus_answer: assert property (
    setup |=> pready ##1 !pready)
    else $error("bus answer timing");

endmodule

// ===== mdseq_adc_model.sv
/*
 Behavioural converter facing the sequencer pump and strobe pins.
 Assumes pump and strobe are driven by the sequencer on pclk.
*/
`timescale 1ns/1ps
module mdseq_adc_model #(
  parameter logic [15:0] SAMPLE = 16'h5a3c
) (
  // Clock
  input wire logic pclk,
  // Control pins
  input wire logic pump_enable_n,
  input wire logic conversion_strobe,
  // Data pins
  output logic [15:0] ext_data
);
  // ----
  // Data lines
  // ----
  // Unpowered lines toggle, so a stale sample never passes for a fresh one
  initial ext_data = 16'h0000;
  always @(posedge pclk) begin
    if (!pump_enable_n || conversion_strobe) begin
      ext_data <= SAMPLE;
    end else begin
      ext_data <= ~ext_data;
    end
  end
endmodule

// ===== mdseq_seq_tb.sv
/*
 Self-checking bench of the sequencer: registers, layouts, mission starts.
 Assumes mdseq_cfg.svh on the include path and the converter model.
*/
`timescale 1ns/1ps
`include "mdseq_cfg.svh"
module mdseq_seq_tb;
  // ----
  // Signals
  // ----
  localparam logic [15:0] EXT = 16'h5a3c;
  typedef struct {logic [13:0] a; logic w; logic [31:0] d; logic [31:0] e;} mdseq_row_t;
  typedef struct {logic [10:0] c; int tb; logic [12:0] b; int db;} mdseq_mode_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic sec_tick = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] rtc_time = 32'h1234_5678;
  logic [15:0] temp_sample = 16'ha5c3;
  logic [3:0] alarm_cond = 4'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, err, pump_enable_n, conversion_strobe, log_we, search_respond, mission_active_flag;
  logic [15:0] ext_data;
  logic [12:0] log_addr;
  logic [7:0] log_wdata;
  logic [20:0] logq[$];
  int bad_count = 0;
  int tests_run = 0;
  int pump_cnt = 0;
  int strobe_at = 0;
  mdseq_row_t regs[12] = '{
    '{`MDSEQ_IDX_SETTLE, 1'b0, 32'h0, 32'h8}, '{`MDSEQ_IDX_TCR_LO, 1'b0, 32'h0, 32'h6b},
    '{`MDSEQ_IDX_TCR_HI, 1'b0, 32'h0, 32'h11}, '{`MDSEQ_IDX_TCL_LO, 1'b0, 32'h0, 32'ha6},
    '{`MDSEQ_IDX_TCL_HI, 1'b0, 32'h0, 32'h12}, '{`MDSEQ_IDX_TCR_HI, 1'b1, 32'hff, 32'h1f},
    '{`MDSEQ_IDX_TCL_HI, 1'b1, 32'hff, 32'h1f}, '{`MDSEQ_IDX_TCR_LO, 1'b1, 32'h5a, 32'h5a},
    '{`MDSEQ_IDX_TCL_LO, 1'b1, 32'h3c, 32'h3c}, '{`MDSEQ_IDX_SETTLE, 1'b1, 32'h2, 32'h2},
    '{`MDSEQ_IDX_PASSWORD, 1'b1, 32'hffff, 32'h0}, '{`MDSEQ_IDX_GP, 1'b1, 32'hcafe, 32'hcafe}};
  mdseq_mode_t modes[5] = '{'{11'h00a, 1, 13'h0000, 0}, '{11'h01a, 1, 13'h1000, 1},
    '{11'h07a, 2, 13'h1000, 2}, '{11'h03a, 2, 13'h1400, 1}, '{11'h05a, 1, 13'h0a00, 2}};

  always #2.5 pclk = ~pclk;

  mdseq_seq #(.TICK_CYCLES(4)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sec_tick(sec_tick), .rtc_time(rtc_time), .temp_sample(temp_sample), .alarm_cond(alarm_cond),
    .ext_data(ext_data), .pump_enable_n(pump_enable_n), .conversion_strobe(conversion_strobe),
    .log_we(log_we), .log_addr(log_addr), .log_wdata(log_wdata),
    .search_respond(search_respond), .mission_active_flag(mission_active_flag)
  );

  mdseq_adc_model #(.SAMPLE(EXT)) adc (
    .pclk(pclk), .pump_enable_n(pump_enable_n), .conversion_strobe(conversion_strobe), .ext_data(ext_data)
  );

  // ----
  // Monitors
  // ----
  always @(posedge pclk) begin
    if (log_we === 1'b1) begin
      logq.push_back({log_addr, log_wdata});
    end
    pump_cnt <= (pump_enable_n === 1'b0) ? pump_cnt + 1 : 0;
    if (conversion_strobe === 1'b1) begin
      strobe_at <= pump_cnt;
    end
  end

  // ----
  // Tasks
  // ----
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  task finish_test;
    $display("checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task apb(input logic w, input logic [13:0] idx, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 50 && pready !== 1'b1; n++) @(posedge pclk);
    if (pready !== 1'b1) begin
      bad_count++;
      finish_test;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wlog(input int k);
    int n;
    for (n = 0; n < 500 && logq.size() < k; n++) @(posedge pclk);
    if (logq.size() < k) begin
      bad_count++;
      finish_test;
    end
  endtask

  // Long gap lets settle and byte writes finish between seconds
  task tick(input int k);
    repeat (k) begin
      @(posedge pclk);
      sec_tick <= 1'b1;
      @(posedge pclk);
      sec_tick <= 1'b0;
      repeat (30) @(posedge pclk);
    end
  endtask

  task start_msn(input logic [10:0] c, input logic [13:0] iv);
    apb(1'b1, `MDSEQ_IDX_CMD, 32'h2);
    apb(1'b1, `MDSEQ_IDX_CMD, 32'h4);
    apb(1'b1, `MDSEQ_IDX_CTRL, 32'(c));
    apb(1'b1, `MDSEQ_IDX_INTERVAL, 32'(iv));
    apb(1'b1, `MDSEQ_IDX_START_DLY, 32'h0);
    apb(1'b0, `MDSEQ_IDX_STATUS, 32'h0);
    chk("memory cleared", 1, rd[1]);
    logq.delete();
    apb(1'b1, `MDSEQ_IDX_CMD, 32'h1);
    apb(1'b0, `MDSEQ_IDX_STATUS, 32'h0);
    chk("status", 1, rd[1:0]);
  endtask

  // ----
  // Main sequence
  // ----
  initial begin
    int n;
    logic [20:0] ex;
    repeat (4) @(posedge pclk);
    chk("pump_enable_n", 1, pump_enable_n);
    chk("active", 0, mission_active_flag);
    presetn <= 1'b1;
    $display("test reset done");
    foreach (regs[i]) begin
      if (regs[i].w) apb(1'b1, regs[i].a, regs[i].d);
      apb(1'b0, regs[i].a, 32'h0);
      chk("register", regs[i].e, rd);
      chk("pslverr", 0, err);
    end
    $display("test registers done");
    foreach (modes[i]) begin
      start_msn(modes[i].c, 14'h1);
      wlog(modes[i].tb + modes[i].db);
      for (n = 0; n < modes[i].tb + modes[i].db; n++) begin
        if (n < modes[i].tb) ex = {13'(n), temp_sample[15 - 8 * n -: 8]};
        else ex = {modes[i].b + 13'(n - modes[i].tb), EXT[15 - 8 * (n - modes[i].tb) -: 8]};
        chk("log entry", ex, logq[n]);
      end
      apb(1'b0, `MDSEQ_IDX_MCOUNT, 32'h0);
      chk("mission count", 1, rd);
      apb(1'b0, `MDSEQ_IDX_DCOUNT, 32'h0);
      chk("device count", 1, rd);
      apb(1'b0, `MDSEQ_IDX_STAMP, 32'h0);
      chk("stamp", rtc_time, rd);
      chk("active", 1, mission_active_flag);
      if (modes[i].db > 0) chk("settle time", 1, strobe_at >= 7 && strobe_at <= 9);
    end
    $display("test layouts done");
    apb(1'b0, 14'h03ff, 32'h0);
    chk("pslverr", 1, err);
    apb(1'b1, `MDSEQ_IDX_SETTLE, 32'h33);
    apb(1'b0, `MDSEQ_IDX_SETTLE, 32'h0);
    chk("settle locked", 2, rd);
    apb(1'b1, `MDSEQ_IDX_GP, 32'h1234_abcd);
    apb(1'b0, `MDSEQ_IDX_GP, 32'h0);
    chk("scratch", 32'h1234_abcd, rd);
    $display("test mission writes done");
    start_msn(11'h00a, 14'h2);
    wlog(1);
    tick(4);
    apb(1'b0, `MDSEQ_IDX_MCOUNT, 32'h0);
    chk("count seconds", 3, rd);
    start_msn(11'h008, 14'h2);
    wlog(1);
    tick(4);
    apb(1'b0, `MDSEQ_IDX_MCOUNT, 32'h0);
    chk("count minutes", 1, rd);
    $display("test interval units done");
    apb(1'b1, `MDSEQ_IDX_CMD, 32'h2);
    apb(1'b1, `MDSEQ_IDX_SETTLE, 32'h0);
    start_msn(11'h01a, 14'h1);
    wlog(2);
    chk("zero settle", 1, strobe_at <= 1);
    $display("test zero settle done");
    start_msn(11'h10e, 14'h1);
    tick(2);
    apb(1'b0, `MDSEQ_IDX_MCOUNT, 32'h0);
    chk("mission count", 0, rd);
    apb(1'b0, `MDSEQ_IDX_DCOUNT, 32'h0);
    chk("device counting", 1, rd != 32'h0);
    chk("no log", 0, logq.size());
    alarm_cond <= 4'h2;
    rtc_time <= 32'h0bad_f00d;
    tick(1);
    apb(1'b0, `MDSEQ_IDX_STAMP, 32'h0);
    chk("alarm stamp", 32'h0bad_f00d, rd);
    apb(1'b0, `MDSEQ_IDX_MCOUNT, 32'h0);
    chk("mission count", 0, rd);
    chk("search", 1, search_respond);
    tick(1);
    wlog(1);
    apb(1'b0, `MDSEQ_IDX_MCOUNT, 32'h0);
    chk("mission count", 1, rd);
    $display("test alarm start done");
    // Rollover off then on; fast seconds keep the 2048-entry fill short
    for (n = 0; n < 2; n++) begin
      start_msn(11'h07a | 11'(n), 14'h1);
      repeat (2048) begin
        repeat (6) @(posedge pclk);
        sec_tick <= 1'b1;
        @(posedge pclk);
        sec_tick <= 1'b0;
      end
      repeat (8) @(posedge pclk);
      apb(1'b0, `MDSEQ_IDX_STATUS, 32'h0);
      chk("full flags", (n == 0) ? 3 : 0, rd[4:3]);
      chk("entries", (n == 0) ? 8192 : 8196, logq.size());
      chk("last address", 13'h1fff, logq[8191][20:8]);
      if (n == 1) chk("wrap address", 13'h1000, logq[8194][20:8]);
    end
    $display("test rollover done");
    finish_test;
  end
endmodule
